// >>> stir_cfg.svh
`ifndef STIR_CFG_SVH
`define STIR_CFG_SVH

// Last oversampling tick of an asynchronous bit (ticks 0 to 15, sixteen per bit)
`define STIR_OS_LAST    4'hF
// Tick on which the three voted samples are complete
`define STIR_OS_VOTE    4'h9
// Length of a three-sixteenths infrared pulse in ticks
`define STIR_IR_316     4'h3
// Decoded low time after an infrared pulse, in ticks
`define STIR_IR_HOLD    5'h10
`define STIR_DATA_W     9
`define STIR_FIFO_DEPTH 4
`define STIR_SPI_BITS   4'h8
`define STIR_MAX_BITS   4'h9
`define STIR_MASK_ALL   9'h1ff

`endif

// >>> stir_pkg.sv
package stir_pkg;

    typedef enum logic [1:0] {
        STIR_ASYNC,
        STIR_SYNC_MST,
        STIR_SYNC_SLV,
        STIR_SPI_MST
    } stir_mode_t;

    typedef enum logic [1:0] {
        STIR_IR_OFF,
        STIR_IR_3_16,
        STIR_IR_FIXED
    } stir_ir_t;

    typedef enum {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} stir_tx_st_t;
    typedef enum {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} stir_rx_st_t;

    typedef struct packed {
        stir_mode_t  mode;
        logic [3:0]  nbits;
        logic        two_stop;
        logic        par_en;
        logic        par_odd;
        logic        mpcm;
        logic        lsb_first;
        logic        tx_en;
        logic        rx_en;
        stir_ir_t    ir;
        logic [7:0]  ir_width;
        logic [15:0] baud_inc;
        logic        en_txc;
        logic        en_dre;
        logic        en_rxc;
    } stir_cfg_t;

    typedef struct packed {
        logic       perr;
        logic       ferr;
        logic [8:0] data;
    } stir_rx_word_t;

endpackage

// >>> stir_top.sv
`timescale 1ns/100ps
`include "stir_cfg.svh"

module stir_fifo #(
    parameter int W     = `STIR_DATA_W,
    parameter int DEPTH = `STIR_FIFO_DEPTH
) (
    input  wire logic         ref_clk_i,
    input  wire logic         reset_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0]   cnt_ff;
    logic [AW:0]   nxt_cnt;
    logic          ready_ff;
    logic          empty_ff;
    logic          push;
    logic          pop;

    // Ready is kept as its own flop so the top output needs no gate
    assign push        = in_valid_i & ready_ff;
    assign pop         = ~empty_ff & out_ready_i;
    assign in_ready_o  = ready_ff;
    assign out_valid_o = ~empty_ff;
    assign out_data_o  = mem[rd_ff];

    always_comb begin
        nxt_cnt = cnt_ff;
        if (push & ~pop) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop & ~push) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem[wr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_ff    <= '0;
            rd_ff    <= '0;
            cnt_ff   <= '0;
            ready_ff <= 1'b1;
            empty_ff <= 1'b1;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
            end
            cnt_ff   <= nxt_cnt;
            ready_ff <= nxt_cnt != (AW + 1)'(DEPTH);
            empty_ff <= nxt_cnt == '0;
        end
    end
endmodule

module stir_top
    import stir_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       reset_i,
    input  wire stir_cfg_t  cfg_i,
    input  wire logic       tx_valid_i,
    input  wire logic [8:0] tx_data_i,
    output logic            tx_ready_o,
    output logic            rx_valid_o,
    input  wire logic       rx_ready_i,
    output logic [8:0]      rx_data_o,
    output logic            rx_perr_o,
    output logic            rx_ferr_o,
    output logic            ovf_o,
    input  wire logic       ovf_clr_i,
    output logic            txc_o,
    input  wire logic       txc_clr_i,
    output logic            irq_txc_o,
    output logic            irq_dre_o,
    output logic            irq_rxc_o,
    output logic            txd_o,
    input  wire logic       rxd_i,
    input  wire logic       xck_i,
    output logic            xck_o,
    output logic            xck_oe_o
);
    stir_tx_st_t   tx_st_ff;
    stir_rx_st_t   rx_st_ff;
    stir_rx_word_t rx_word_ff;
    logic [15:0] acc_ff;
    logic        tick_ff;
    logic [2:0]  xs_ff;
    logic [1:0]  rs_ff;
    logic [2:0]  v_ff;
    logic [4:0]  dec_ff;
    logic        xck_ff;
    logic        oe_ff;
    logic [3:0]  tx_os_ff;
    logic [3:0]  tx_cnt_ff;
    logic [8:0]  tx_sh_ff;
    logic        tx_par_ff;
    logic        tx_bit_ff;
    logic        txc_ff;
    logic        txd_ff;
    logic [7:0]  ir_cnt_ff;
    logic [3:0]  rx_os_ff;
    logic [3:0]  rx_cnt_ff;
    logic [8:0]  rx_sh_ff;
    logic [8:0]  nxt_rx_sh;
    logic        rx_pc_ff;
    logic        rx_pe_ff;
    logic        rx_addr_ff;
    logic        rx_valid_ff;
    logic        ovf_ff;
    logic        irq_txc_ff;
    logic        irq_dre_ff;
    logic        irq_rxc_ff;
    logic        spi;
    logic        asyn;
    logic        mst;
    logic        ir_on;
    logic [3:0]  nb;
    logic [8:0]  mask;
    logic        rise;
    logic        fall;
    logic        busy;
    logic        tx_step;
    logic        tx_last;
    logic        tx_load;
    logic        tx_done;
    logic        f_ready;
    logic        f_valid;
    logic [8:0]  f_data;
    logic        line;
    logic        vote;
    logic        samp;
    logic        bitv;
    logic        rx_fin;
    logic        rx_keep;
    logic        ir_out;

    assign spi   = cfg_i.mode == STIR_SPI_MST;
    assign asyn  = cfg_i.mode == STIR_ASYNC;
    assign mst   = spi | (cfg_i.mode == STIR_SYNC_MST);
    // infrared codec usable in asynchronous mode only
    assign ir_on = asyn & (cfg_i.ir != STIR_IR_OFF);
    // data width from configuration; SPI fixed to a byte
    assign nb    = spi ? `STIR_SPI_BITS : cfg_i.nbits;
    assign mask  = ~(`STIR_MASK_ALL << nb);

    // fractional accumulator, tick rate = clk * inc / 65536
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            {tick_ff, acc_ff} <= {1'b0, acc_ff} + {1'b0, cfg_i.baud_inc};
        end
    end

    // Pins cross into this clock through two stages before use
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            xs_ff <= '0;
            rs_ff <= 2'h3;
        end else begin
            xs_ff <= {xs_ff[1:0], xck_i};
            rs_ff <= {rs_ff[0], rxd_i};
        end
    end

    // master clock toggles at most once per tick, so at most clk/2
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            xck_ff <= 1'b0;
            oe_ff  <= 1'b0;
        end else begin
            oe_ff <= mst;
            if (!mst || !busy) begin
                xck_ff <= 1'b0;
            end else if (tick_ff) begin
                xck_ff <= ~xck_ff;
            end
        end
    end

    // slave edges come from the synchronised external clock
    assign rise = mst ? (tick_ff & busy & ~xck_ff) : (xs_ff[1] & ~xs_ff[2]);
    assign fall = mst ? (tick_ff & busy & xck_ff) : (xs_ff[2] & ~xs_ff[1]);

    // four-word buffer ahead of the shifter
    stir_fifo #(
        .W     (`STIR_DATA_W),
        .DEPTH (`STIR_FIFO_DEPTH)
    ) u_txf (
        .ref_clk_i   (ref_clk_i),
        .reset_i     (reset_i),
        .in_valid_i  (tx_valid_i),
        .in_ready_o  (f_ready),
        .in_data_i   (tx_data_i),
        .out_valid_o (f_valid),
        .out_ready_i (tx_load),
        .out_data_o  (f_data)
    );

    assign busy    = tx_st_ff != T_IDLE;
    // sixteen ticks per asynchronous bit, at most clk/16
    assign tx_step = asyn ? (tick_ff & (tx_os_ff == `STIR_OS_LAST)) : fall;
    assign tx_last = tx_step & (((tx_st_ff == T_STOP) &
                     (~cfg_i.two_stop | tx_cnt_ff[0])) |
                     (spi & (tx_st_ff == T_DATA) &
                     (tx_cnt_ff == nb - 4'h1)));
    // next word loads on the last step, no idle bit between
    assign tx_load = f_valid & cfg_i.tx_en & (~busy | tx_last);
    assign tx_done = tx_last & ~tx_load;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_os_ff <= '0;
        end else if (tx_load) begin
            tx_os_ff <= '0;
        end else if (tick_ff & busy) begin
            tx_os_ff <= tx_os_ff + 4'h1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_st_ff  <= T_IDLE;
            tx_cnt_ff <= '0;
            tx_sh_ff  <= '0;
            tx_par_ff <= 1'b0;
            tx_bit_ff <= 1'b1;
        end else if (tx_load) begin
            tx_sh_ff  <= f_data;
            // parity over the configured data bits only
            tx_par_ff <= (^(f_data & mask)) ^ cfg_i.par_odd;
            tx_cnt_ff <= '0;
            // SPI skips the start bit; start bit low
            tx_st_ff  <= spi ? T_DATA : T_START;
            tx_bit_ff <= spi ? (cfg_i.lsb_first ? f_data[0] : f_data[7])
                             : 1'b0;
        end else if (tx_step) begin
            case (tx_st_ff)
                T_START: begin
                    tx_st_ff  <= T_DATA;
                    tx_bit_ff <= tx_sh_ff[0];
                end
                T_DATA: begin
                    if (tx_cnt_ff == nb - 4'h1) begin
                        tx_cnt_ff <= '0;
                        tx_bit_ff <= (cfg_i.par_en & ~spi) ? tx_par_ff : 1'b1;
                        tx_st_ff  <= spi ? T_IDLE
                                   : cfg_i.par_en ? T_PAR : T_STOP;
                    end else begin
                        tx_cnt_ff <= tx_cnt_ff + 4'h1;
                        // bit order chosen in SPI mode
                        if (spi & ~cfg_i.lsb_first) begin
                            tx_sh_ff  <= tx_sh_ff << 1;
                            tx_bit_ff <= tx_sh_ff[6];
                        end else begin
                            tx_sh_ff  <= tx_sh_ff >> 1;
                            tx_bit_ff <= tx_sh_ff[1];
                        end
                    end
                end
                T_PAR: begin
                    tx_st_ff  <= T_STOP;
                    tx_bit_ff <= 1'b1;
                end
                T_STOP: begin
                    // one or two high stop bits
                    tx_bit_ff <= 1'b1;
                    if (tx_last) begin
                        tx_st_ff <= T_IDLE;
                    end else begin
                        tx_cnt_ff <= tx_cnt_ff + 4'h1;
                    end
                end
                default: tx_st_ff <= T_IDLE;
            endcase
        end
    end

    // pulse marks a zero bit; width 3/16 bit or programmed clocks
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ir_cnt_ff <= '0;
        end else if (tx_load | tx_step) begin
            ir_cnt_ff <= cfg_i.ir_width;
        end else if (ir_cnt_ff != '0) begin
            ir_cnt_ff <= ir_cnt_ff - 8'h01;
        end
    end
    assign ir_out = ~tx_bit_ff & busy & ((cfg_i.ir == STIR_IR_3_16) ?
                    (tx_os_ff < `STIR_IR_316) : (ir_cnt_ff != '0));

    // Decoder holds the line low one bit time after each pulse
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            dec_ff <= '0;
        end else if (rs_ff[1]) begin
            dec_ff <= `STIR_IR_HOLD;
        end else if (tick_ff & (dec_ff != '0)) begin
            dec_ff <= dec_ff - 5'h01;
        end
    end
    assign line = ir_on ? (dec_ff == '0) : rs_ff[1];

    // majority of three oversamples as a low-pass filter
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            v_ff <= 3'h7;
        end else if (tick_ff) begin
            v_ff <= {v_ff[1:0], line};
        end
    end
    assign vote = (v_ff[0] & v_ff[1]) | (v_ff[0] & v_ff[2]) |
                  (v_ff[1] & v_ff[2]);
    assign samp = asyn ? (tick_ff & (rx_os_ff == `STIR_OS_VOTE)) : rise;
    assign bitv = asyn ? vote : line;

    always_comb begin
        nxt_rx_sh = rx_sh_ff;
        if ((rx_st_ff == R_DATA) & samp) begin
            nxt_rx_sh = (spi & ~cfg_i.lsb_first) ? {rx_sh_ff[7:0], bitv}
                                                 : {bitv, rx_sh_ff[8:1]};
        end
    end

    assign rx_fin  = samp & ((rx_st_ff == R_STOP) | (spi &
                     (rx_st_ff == R_DATA) & (rx_cnt_ff == nb - 4'h1)));
    // unaddressed receiver drops frames whose address bit is clear
    assign rx_keep = rx_fin & cfg_i.rx_en &
                     ~(cfg_i.mpcm & ~spi & ~rx_addr_ff);

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_st_ff   <= R_IDLE;
            rx_os_ff   <= '0;
            rx_cnt_ff  <= '0;
            rx_sh_ff   <= '0;
            rx_pc_ff   <= 1'b0;
            rx_pe_ff   <= 1'b0;
            rx_addr_ff <= 1'b0;
        end else begin
            rx_sh_ff <= nxt_rx_sh;
            if (tick_ff) begin
                rx_os_ff <= rx_os_ff + 4'h1;
            end
            case (rx_st_ff)
                R_IDLE: begin
                    rx_cnt_ff <= '0;
                    rx_pc_ff  <= 1'b0;
                    rx_pe_ff  <= 1'b0;
                    rx_os_ff  <= '0;
                    if (~cfg_i.rx_en) begin
                        rx_st_ff <= R_IDLE;
                    end else if (spi) begin
                        rx_st_ff <= tx_load ? R_DATA : R_IDLE;
                    // a low level after idle high starts a frame
                    end else if ((asyn ? tick_ff : rise) & ~line) begin
                        rx_st_ff <= asyn ? R_START : R_DATA;
                    end
                end
                R_START: begin
                    // start not confirmed at mid bit is dropped
                    if (samp) begin
                        rx_st_ff <= bitv ? R_IDLE : R_DATA;
                    end
                end
                R_DATA: begin
                    if (samp) begin
                        rx_pc_ff <= rx_pc_ff ^ bitv;
                        if (rx_cnt_ff == nb - 4'h1) begin
                            // last data bit is the address mark
                            rx_addr_ff <= bitv;
                            rx_st_ff   <= spi ? R_IDLE
                                        : cfg_i.par_en ? R_PAR : R_STOP;
                        end else begin
                            rx_cnt_ff <= rx_cnt_ff + 4'h1;
                        end
                    end
                end
                R_PAR: begin
                    if (samp) begin
                        rx_pe_ff <= rx_pc_ff ^ bitv ^ cfg_i.par_odd;
                        rx_st_ff <= R_STOP;
                    end
                end
                R_STOP: begin
                    if (samp) begin
                        rx_st_ff <= R_IDLE;
                    end
                end
                default: rx_st_ff <= R_IDLE;
            endcase
        end
    end

    // hold register, framing and overrun flags
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_valid_ff <= 1'b0;
            rx_word_ff  <= '0;
            ovf_ff      <= 1'b0;
        end else begin
            ovf_ff <= (rx_keep & rx_valid_ff & ~rx_ready_i) |
                      (ovf_ff & ~ovf_clr_i);
            if (rx_keep & (~rx_valid_ff | rx_ready_i)) begin
                rx_valid_ff     <= 1'b1;
                rx_word_ff.data <= ((spi & ~cfg_i.lsb_first) ? nxt_rx_sh
                                   : nxt_rx_sh >> (`STIR_MAX_BITS - nb))
                                   & mask;
                rx_word_ff.perr <= rx_pe_ff & ~spi;
                rx_word_ff.ferr <= (rx_st_ff == R_STOP) & ~bitv;
            end else if (rx_ready_i) begin
                rx_valid_ff <= 1'b0;
            end
        end
    end

    // three separately enabled sources; same in SPI mode
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            txc_ff     <= 1'b0;
            irq_txc_ff <= 1'b0;
            irq_dre_ff <= 1'b0;
            irq_rxc_ff <= 1'b0;
            txd_ff     <= 1'b1;
        end else begin
            txc_ff     <= tx_done | (txc_ff & ~txc_clr_i);
            irq_txc_ff <= txc_ff & cfg_i.en_txc;
            irq_dre_ff <= f_ready & cfg_i.tx_en & cfg_i.en_dre;
            irq_rxc_ff <= rx_valid_ff & cfg_i.en_rxc;
            txd_ff     <= ir_on ? ir_out : tx_bit_ff;
        end
    end

    assign tx_ready_o = f_ready;
    assign rx_valid_o = rx_valid_ff;
    assign rx_data_o  = rx_word_ff.data;
    assign rx_perr_o  = rx_word_ff.perr;
    assign rx_ferr_o  = rx_word_ff.ferr;
    assign ovf_o      = ovf_ff;
    assign txc_o      = txc_ff;
    assign irq_txc_o  = irq_txc_ff;
    assign irq_dre_o  = irq_dre_ff;
    assign irq_rxc_o  = irq_rxc_ff;
    assign txd_o      = txd_ff;
    assign xck_o      = xck_ff;
    assign xck_oe_o   = oe_ff;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_false_start;
        (rx_st_ff == R_START) && samp && bitv;
    endsequence
    sequence s_last_with_data;
        tx_last && f_valid && cfg_i.tx_en && !spi;
    endsequence

    chk_start_low: assert property (tx_st_ff == T_START |-> !tx_bit_ff)
        else $error("start bit not low");
    chk_stop_high: assert property (tx_st_ff == T_STOP |-> tx_bit_ff)
        else $error("stop bit not high");
    chk_async_rate: assert property (asyn && tx_step |=> !tx_step [*8])
        else $error("asynchronous bit too short");
    chk_sync_half: assert property (rise |=> !rise)
        else $error("sync clock above half rate");
    chk_false_start: assert property (s_false_start |=> rx_st_ff == R_IDLE)
        else $error("false start not rejected");
    chk_back_to_back: assert property (s_last_with_data |=> tx_st_ff == T_START)
        else $error("gap between buffered frames");
    chk_overrun_flag: assert property (rx_keep && rx_valid_ff && !rx_ready_i
        |=> ovf_ff && $stable(rx_word_ff))
        else $error("overrun not flagged");
    chk_mp_discard: assert property (rx_fin && cfg_i.mpcm && !spi
        && !rx_addr_ff |=> !$rose(rx_valid_ff))
        else $error("data frame kept while unaddressed");
    chk_txc_irq: assert property (tx_done && cfg_i.en_txc
        |=> ##1 irq_txc_ff)
        else $error("transmit complete not signalled");
    chk_spi_noframe: assert property (spi && busy
        |-> tx_st_ff == T_DATA)
        else $error("framing state in SPI mode");
endmodule

// >>> stir_remote_node.sv
`timescale 1ns/100ps
module stir_remote_node #(
    parameter int BIT = 32
) (
    input  wire logic       ref_clk_i,
    input  wire logic       line_i,
    output logic            line_o,
    input  wire logic [3:0] nbits_i,
    input  wire logic       par_en_i,
    input  wire logic       send_i,
    input  wire logic [9:0] word_i,
    input  wire logic       stop_i,
    output logic            got_o,
    output logic [10:0]     got_o_word
);
    initial begin
        got_o = 1'b0;
        got_o_word = '0;
        forever begin
            @(negedge line_i);
            repeat (BIT / 2) @(posedge ref_clk_i);
            got_o_word <= '0;
            for (int i = 0; i <= nbits_i + par_en_i; i++) begin
                repeat (BIT) @(posedge ref_clk_i);
                got_o_word[i == nbits_i + par_en_i ? 10 : i] <= line_i;
            end
            got_o <= 1'b1;
            @(posedge ref_clk_i);
            got_o <= 1'b0;
        end
    end
    initial begin
        line_o = 1'b1;
        forever begin
            @(posedge ref_clk_i);
            if (send_i) begin
                line_o <= 1'b0;
                for (int i = 0; i <= nbits_i + par_en_i; i++) begin
                    repeat (BIT) @(posedge ref_clk_i);
                    line_o <= i == nbits_i + par_en_i ? stop_i : word_i[i];
                end
                repeat (BIT) @(posedge ref_clk_i);
                line_o <= 1'b1;
            end
        end
    end
endmodule

// >>> serial_transceiver_with_ir_codec_test.sv
`timescale 1ns/100ps
module serial_transceiver_with_ir_codec_test
    import stir_pkg::*;
;
    localparam int BIT = 32;
    `define CHK(nm, ex, gt) begin logic [31:0] e, g; e = ex; g = gt; \
        cmp_count++; if (g !== e) begin errors++; \
        $display("wrong value %s exp %h got %h", nm, e, g); end end
    stir_cfg_t   cfg;
    logic        ref_clk_i, reset_i, tx_valid, rx_ready, ovf_clr, txc_clr;
    logic        send, sstop, tx_ready, rx_valid, perr, ferr, ovf, txc;
    logic        itxc, idre, irxc, txd, rxd, got, xck, xoe;
    logic [8:0]  tx_data, rx_data, d;
    logic [9:0]  sword;
    logic [10:0] gword, txq[$], rxq[$];
    int          errors, cmp_count, seed;
    stir_top uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .cfg_i(cfg),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
        .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .rx_data_o(rx_data),
        .rx_perr_o(perr), .rx_ferr_o(ferr), .ovf_o(ovf),
        .ovf_clr_i(ovf_clr), .txc_o(txc), .txc_clr_i(txc_clr),
        .irq_txc_o(itxc), .irq_dre_o(idre), .irq_rxc_o(irxc), .txd_o(txd),
        .rxd_i(rxd), .xck_i(1'b0), .xck_o(xck), .xck_oe_o(xoe));
    stir_remote_node #(.BIT(BIT)) peer (.ref_clk_i(ref_clk_i),
        .line_i(txd), .line_o(rxd), .nbits_i(cfg.nbits),
        .par_en_i(cfg.par_en), .send_i(send), .word_i(sword),
        .stop_i(sstop), .got_o(got), .got_o_word(gword));
    function automatic logic par(input logic [8:0] v);
        return ^(v & ~(9'h1ff << cfg.nbits)) ^ cfg.par_odd;
    endfunction
    task automatic push(input logic [8:0] v);
        tx_valid = 1'b1;
        tx_data = v & ~(9'h1ff << cfg.nbits);
        txq.push_back({1'b1, 10'(tx_data)
            | 10'(cfg.par_en & par(tx_data)) << cfg.nbits});
        @(posedge ref_clk_i);
        while (tx_ready !== 1'b1) @(posedge ref_clk_i);
        #2;
    endtask
    // Offered frames only land in the queue when the receiver should keep them
    task automatic frame(input logic pbad, sbad, keep);
        d = 9'($random(seed)) & ~(9'h1ff << cfg.nbits);
        if (cfg.mpcm) d[8] = keep;
        sword = 10'(d) | 10'(cfg.par_en & (par(d) ^ pbad)) << cfg.nbits;
        sstop = ~sbad;
        send = 1'b1;
        @(posedge ref_clk_i);
        #2 send = 1'b0;
        if (keep) rxq.push_back({sbad, pbad, d});
        repeat ((cfg.nbits + cfg.par_en + 3) * BIT) @(posedge ref_clk_i);
        #2;
    endtask
    task automatic tx_done;
        for (int i = 0; i < 4000 && txc !== 1'b1; i++) @(posedge ref_clk_i);
        @(posedge ref_clk_i);
        #2 `CHK("idle flags", 4'hF, {itxc, idre, txd, txc})
        txc_clr = 1'b1;
        @(posedge ref_clk_i);
        #2 txc_clr = 1'b0;
        `CHK("txc clear", 1'b0, txc)
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        if (got === 1'b1) `CHK("line frame", txq.pop_front(), gword)
        if (rx_valid === 1'b1 && rx_ready) `CHK("rx word", rxq.pop_front(),
            {ferr, perr, rx_data})
    end
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        errors++;
        report_and_stop;
    end
    initial begin
        seed = 32'h6e13;
        errors = 0;
        cmp_count = 0;
        {reset_i, tx_valid, tx_data, rx_ready} = {1'b1, 10'h000, 1'b1};
        {ovf_clr, txc_clr, send, sstop, sword} = {4'h1, 10'h000};
        cfg = '0;
        cfg.mode = STIR_ASYNC;
        cfg.ir = STIR_IR_OFF;
        cfg.baud_inc = 16'h8000;
        {cfg.tx_en, cfg.rx_en, cfg.en_txc, cfg.en_dre, cfg.en_rxc} = 5'h1F;
        repeat (16) @(posedge ref_clk_i);
        #2 reset_i = 1'b0;
        for (int i = 0; i < 10; i++) begin
            cfg.nbits = 4'(5 + i / 2);
            cfg.par_en = i[0];
            cfg.par_odd = i[1];
            cfg.two_stop = i[2];
            for (int k = 0; k < 5; k++) push(9'($random(seed)));
            tx_valid = 1'b0;
            repeat (2) @(posedge ref_clk_i);
            #2 `CHK("fifo full", 2'b00, {tx_ready, idre})
            tx_done;
        end
        $display("test transmit done");
        for (int i = 0; i < 6; i++) begin
            cfg.nbits = 4'(5 + i % 5);
            cfg.par_en = i > 1;
            frame(i == 3, i == 4, 1'b1);
        end
        rx_ready = 1'b0;
        frame(1'b0, 1'b0, 1'b1);
        frame(1'b0, 1'b0, 1'b0);
        `CHK("overrun", 3'b111, {ovf, rx_valid, irxc})
        rx_ready = 1'b1;
        ovf_clr = 1'b1;
        @(posedge ref_clk_i);
        #2 ovf_clr = 1'b0;
        `CHK("overrun clear", 1'b0, ovf)
        {cfg.mpcm, cfg.nbits, cfg.par_en} = {1'b1, 4'h9, 1'b0};
        frame(1'b0, 1'b0, 1'b0);
        frame(1'b0, 1'b0, 1'b1);
        // Idle high rxd shifts in all ones; an all-ones word keeps txd high
        cfg.mode = STIR_SPI_MST;
        rxq.push_back(11'h0ff);
        tx_data = 9'h0ff;
        tx_valid = 1'b1;
        @(posedge ref_clk_i);
        #2 tx_valid = 1'b0;
        tx_done;
        `CHK("spi clock pins", 2'b10, {xoe, xck})
        `CHK("queues", 0, txq.size() + rxq.size())
        $display("test receive done");
        report_and_stop;
    end
endmodule
